// ===== hdl/bus_align_pkg.sv
// Constants and types shared by the external bus alignment block
package bus_align_pkg;
    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG
    } access_size_e;

    typedef enum logic [1:0] {
        WIDTH_8,
        WIDTH_16,
        WIDTH_32
    } dev_width_e;

    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 32;
    localparam int          LANES       = 4;
    localparam logic [1:0]  BEAT_RESET  = 2'h0;
    localparam logic        BIG_ENDIAN  = 1'h0;
endpackage

// ===== hdl/lane_steer.sv
// Combinational lane steering for one external bus cycle
`timescale 1ns/10ps
`default_nettype none
module lane_steer (
    // Access description
    input  wire logic [1:0]  size_i,
    input  wire logic [1:0]  width_i,
    input  wire logic        little_i,
    input  wire logic [1:0]  offset_i,
    input  wire logic [1:0]  beat_i,
    input  wire logic [31:0] wdata_i,
    // External lanes
    output logic      [31:0] lane_data_o,
    output logic      [3:0]  lane_en_o
);
    logic [1:0]  lane;
    logic [1:0]  pick;
    logic [7:0]  bsel;
    logic [15:0] hsel;

    always_comb begin
        lane_data_o = 32'h0;
        lane_en_o   = 4'h0;
        lane        = 2'h0;
        pick        = 2'h0;
        bsel        = 8'h0;
        hsel        = 16'h0;
        case (width_i)
            bus_align_pkg::WIDTH_32: begin
                if (size_i == bus_align_pkg::SIZE_LONG) begin
                    lane_data_o = wdata_i;
                    lane_en_o   = 4'hf;
                end else if (size_i == bus_align_pkg::SIZE_WORD) begin
                    if (offset_i[1] ^ ~little_i) begin
                        lane_data_o = {wdata_i[15:0], 16'h0};
                        lane_en_o   = 4'hc;
                    end else begin
                        lane_data_o = {16'h0, wdata_i[15:0]};
                        lane_en_o   = 4'h3;
                    end
                end else begin
                    lane = little_i ? offset_i : ~offset_i;
                    lane_data_o = {24'h0, wdata_i[7:0]} << {lane, 3'h0};
                    lane_en_o   = 4'h1 << lane;
                end
            end
            bus_align_pkg::WIDTH_16: begin
                if (size_i == bus_align_pkg::SIZE_LONG) begin
                    if (beat_i[0] ^ ~little_i)
                        hsel = wdata_i[31:16];
                    else
                        hsel = wdata_i[15:0];
                    lane_data_o = {16'h0, hsel};
                    lane_en_o   = 4'h3;
                end else if (size_i == bus_align_pkg::SIZE_WORD) begin
                    lane_data_o = {16'h0, wdata_i[15:0]};
                    lane_en_o   = 4'h3;
                end else if (offset_i[0] ^ ~little_i) begin
                    lane_data_o = {16'h0, wdata_i[7:0], 8'h0};
                    lane_en_o   = 4'h2;
                end else begin
                    lane_data_o = {24'h0, wdata_i[7:0]};
                    lane_en_o   = 4'h1;
                end
            end
            default: begin
                if (size_i == bus_align_pkg::SIZE_LONG)
                    pick = little_i ? beat_i : ~beat_i;
                else if (size_i == bus_align_pkg::SIZE_WORD)
                    pick = {1'b0, beat_i[0] ^ ~little_i};
                else
                    pick = 2'h0;
                bsel = wdata_i[pick*8 +: 8];
                lane_data_o = {24'h0, bsel};
                lane_en_o   = 4'h1;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== hdl/bus_align.sv
// Byte-lane steering and access splitting for the external bus
`timescale 1ns/10ps
`default_nettype none
// How it works
// - An 8-bit big-endian device uses lane 0 only; words go high byte first over two cycles, longwords top byte first over four.
// - A 32-bit little-endian device puts byte k on lane k and words at 0/2 on the low/high lane pair.
// - A 32-bit device takes a longword in one cycle on all four lanes with all strobes.
// - A 16-bit little-endian device puts even bytes on lane 0, odd on lane 1, and longwords low half first.
// - An 8-bit little-endian device uses lane 0 only; words and longwords go low byte first.
// - A 16-bit or 8-bit device never sees data or strobes on the upper two lanes.
// - A 16-bit big-endian device puts even bytes on lane 1, odd on lane 0, and longwords high half first.
// - Endianness is caught from the select pin at the first clock edge after reset is released: low is big-endian, high is little-endian.
// - Splitting and alignment happen in hardware without any software help.
// - A 32-bit big-endian device puts byte 0 on the top lane and byte 3 on lane 0, words at 0 on the upper pair.
module bus_align (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Configuration
    input  wire logic        endian_select_pin_i,
    input  wire logic [1:0]  dev_width_i,
    // Internal access request
    input  wire logic        req_i,
    input  wire logic [1:0]  size_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    output logic             busy_o,
    output logic             done_o,
    // External bus, one cycle per beat
    output logic             ext_valid_o,
    input  wire logic        ext_ready_i,
    output logic [31:0]      ext_addr_o,
    output logic [31:0]      ext_data_o,
    output logic             lane3_write_strobe_o,
    output logic             lane2_write_strobe_o,
    output logic             lane1_write_strobe_o,
    output logic             lane0_write_strobe_o,
    output logic             little_endian_o
);
    typedef enum logic [1:0] {
        ST_STRAP,
        ST_IDLE,
        ST_BEAT
    } state_e;

    state_e      state_q,  state_d;
    logic        busy_q,   busy_d;
    logic        little_q, little_d;
    // Request caught when the access is taken
    logic [1:0]  size_q,   size_d;
    logic [1:0]  width_q,  width_d;
    logic [1:0]  beat_q,   beat_d;
    logic [1:0]  last_q,   last_d;
    logic [31:0] base_q,   base_d;
    logic [31:0] wdata_q,  wdata_d;
    // Beat standing on the external bus
    logic        valid_q,  valid_d;
    logic        done_q,   done_d;
    logic [31:0] addr_q,   addr_d;
    logic [31:0] data_q,   data_d;
    logic [3:0]  stb_q,    stb_d;
    // Steering of the beat that goes out at the next edge
    logic [31:0] steer_data;
    logic [3:0]  steer_en;
    logic [1:0]  nbeat;

    // Number of cycles minus one for an access on a given device width
    function automatic logic [1:0] beats_minus_one(input logic [1:0] sz,
                                                   input logic [1:0] wd);
        logic [1:0] r;
        r = 2'h0;
        case (wd)
            bus_align_pkg::WIDTH_32: r = 2'h0;
            bus_align_pkg::WIDTH_16: begin
                if (sz == bus_align_pkg::SIZE_LONG)
                    r = 2'h1;
            end
            default: begin
                // Code 3 falls back to the narrowest device, as steering does
                if (sz == bus_align_pkg::SIZE_LONG)
                    r = 2'h3;
                else if (sz == bus_align_pkg::SIZE_WORD)
                    r = 2'h1;
            end
        endcase
        return r;
    endfunction

    // Address step of one cycle, equal to the device width in bytes
    function automatic logic [31:0] step_of(input logic [1:0] wd);
        logic [31:0] s;
        case (wd)
            bus_align_pkg::WIDTH_32: s = 32'h4;
            bus_align_pkg::WIDTH_16: s = 32'h2;
            default:                 s = 32'h1;
        endcase
        return s;
    endfunction

    lane_steer u_steer (
        .size_i      (size_q),
        .width_i     (width_q),
        .little_i    (little_q),
        .offset_i    (base_q[1:0]),
        .beat_i      (beat_d),
        .wdata_i     (wdata_q),
        .lane_data_o (steer_data),
        .lane_en_o   (steer_en)
    );

    // All decisions live here; the clocked process only registers them
    always_comb begin
        state_d  = state_q;
        little_d = little_q;
        size_d   = size_q;
        width_d  = width_q;
        beat_d   = beat_q;
        last_d   = last_q;
        base_d   = base_q;
        wdata_d  = wdata_q;
        valid_d  = valid_q;
        done_d   = 1'b0;
        addr_d   = addr_q;
        data_d   = data_q;
        stb_d    = stb_q;
        nbeat    = beat_q + 2'h1;

        case (state_q)
            ST_STRAP: begin
                // Pin is caught by a clock edge after release, not by reset
                little_d = endian_select_pin_i;
                state_d  = ST_IDLE;
            end
            ST_IDLE: begin
                if (req_i) begin
                    // Width is taken per access, so mixed areas can share it
                    size_d  = size_i;
                    width_d = dev_width_i;
                    last_d  = beats_minus_one(size_i, dev_width_i);
                    base_d  = addr_i;
                    wdata_d = wdata_i;
                    beat_d  = bus_align_pkg::BEAT_RESET;
                    state_d = ST_BEAT;
                end
            end
            ST_BEAT: begin
                if (!valid_q) begin
                    // First beat: steering sees the registered request
                    valid_d = 1'b1;
                    addr_d  = base_q;
                    data_d  = steer_data;
                    stb_d   = steer_en;
                end else if (ext_ready_i) begin
                    if (beat_q == last_q) begin
                        // Strobes drop with valid so no lane stays enabled
                        valid_d = 1'b0;
                        stb_d   = 4'h0;
                        done_d  = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        beat_d = nbeat;
                        addr_d = addr_q + step_of(width_q);
                        data_d = steer_data;
                        stb_d  = steer_en;
                    end
                end
            end
            default: state_d = ST_STRAP;
        endcase
        // Busy is registered so the output comes straight from a flop
        busy_d = (state_d != ST_IDLE);
    end

    // Reset parks the block in the strap cycle with busy high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q  <= ST_STRAP;
            busy_q   <= 1'b1;
            little_q <= bus_align_pkg::BIG_ENDIAN;
            size_q   <= 2'h0;
            width_q  <= 2'h0;
            beat_q   <= bus_align_pkg::BEAT_RESET;
            last_q   <= 2'h0;
            base_q   <= 32'h0;
            wdata_q  <= 32'h0;
            valid_q  <= 1'b0;
            done_q   <= 1'b0;
            addr_q   <= 32'h0;
            data_q   <= 32'h0;
            stb_q    <= 4'h0;
        end else begin
            state_q  <= state_d;
            busy_q   <= busy_d;
            little_q <= little_d;
            size_q   <= size_d;
            width_q  <= width_d;
            beat_q   <= beat_d;
            last_q   <= last_d;
            base_q   <= base_d;
            wdata_q  <= wdata_d;
            valid_q  <= valid_d;
            done_q   <= done_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            stb_q    <= stb_d;
        end
    end

    // Outputs are plain register taps
    assign busy_o               = busy_q;
    assign done_o               = done_q;
    assign ext_valid_o          = valid_q;
    assign ext_addr_o           = addr_q;
    assign ext_data_o           = data_q;
    assign lane3_write_strobe_o = stb_q[3];
    assign lane2_write_strobe_o = stb_q[2];
    assign lane1_write_strobe_o = stb_q[1];
    assign lane0_write_strobe_o = stb_q[0];
    assign little_endian_o      = little_q;
endmodule
`default_nettype wire

// ===== test/align_sva.sv
// Property checker bound to the external bus alignment block
`timescale 1ns/10ps
`default_nettype none
module align_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [1:0]  dev_width_i,
    input wire logic        req_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        ext_valid_o,
    input wire logic        ext_ready_i,
    input wire logic [31:0] ext_addr_o,
    input wire logic [31:0] ext_data_o,
    input wire logic        lane3_write_strobe_o,
    input wire logic        lane2_write_strobe_o,
    input wire logic        lane1_write_strobe_o,
    input wire logic        lane0_write_strobe_o,
    input wire logic        little_endian_o
);
    logic [3:0] strb;
    assign strb = {lane3_write_strobe_o, lane2_write_strobe_o,
                   lane1_write_strobe_o, lane0_write_strobe_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s; req_i && !busy_o; endsequence
    sequence accept_s; ext_valid_o && ext_ready_i; endsequence
    take_answer_a: assert property (
        take_s |=> busy_o ##1 ext_valid_o) else $error("late first beat");
    done_pulse_a: assert property (
        accept_s ##1 !ext_valid_o |-> done_o) else $error("done missing");
    done_cause_a: assert property (
        done_o |-> $past(ext_valid_o && ext_ready_i) && strb == 4'h0)
        else $error("done without final beat");
    beat_hold_a: assert property (
        ext_valid_o && !ext_ready_i |=> ext_valid_o && $stable(ext_addr_o)
        && $stable(ext_data_o) && $stable(strb)) else $error("beat moved");
    addr_step_a: assert property (
        accept_s ##1 ext_valid_o |-> ext_addr_o == $past(ext_addr_o) +
        ((dev_width_i == 2'h1) ? 32'h2 :
         (dev_width_i == 2'h2) ? 32'h4 : 32'h1)) else $error("bad step");
    idle_strobes_a: assert property (
        !ext_valid_o |-> strb == 4'h0) else $error("strobe while idle");
    narrow_upper_a: assert property (
        ext_valid_o && dev_width_i != 2'h2 |-> strb[3:2] == 2'h0
        && ext_data_o[31:16] == 16'h0) else $error("upper lanes used");
    byte_lane_a: assert property (
        ext_valid_o && (dev_width_i == 2'h0 || dev_width_i == 2'h3)
        |-> strb == 4'h1)
        else $error("byte device lane wrong");
    endian_hold_a: assert property (
        $past(!busy_o) && !busy_o |-> $stable(little_endian_o))
        else $error("endianness changed");
endmodule
bind bus_align align_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .dev_width_i(dev_width_i), .req_i(req_i), .busy_o(busy_o),
    .done_o(done_o), .ext_valid_o(ext_valid_o), .ext_ready_i(ext_ready_i),
    .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o),
    .lane3_write_strobe_o(lane3_write_strobe_o),
    .lane2_write_strobe_o(lane2_write_strobe_o),
    .lane1_write_strobe_o(lane1_write_strobe_o),
    .lane0_write_strobe_o(lane0_write_strobe_o),
    .little_endian_o(little_endian_o));
`default_nettype wire

// ===== test/ext_device.sv
// Far-side memory model that accepts beats after a chosen stall
`timescale 1ns/10ps
`default_nettype none
module ext_device (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       valid_i,
    input  wire logic [1:0] stall_i,
    output logic            ready_o
);
    logic [1:0] wait_q;
    logic [1:0] wait_d;
    // Holding ready back makes the block keep each beat standing
    assign ready_o = valid_i && (wait_q == stall_i);
    always_comb begin
        wait_d = (valid_i && !ready_o) ? wait_q + 2'h1 : 2'h0;
    end
    always_ff @(posedge clk_i) begin
        wait_q <= rst_i ? 2'h0 : wait_d;
    end
endmodule
`default_nettype wire

// ===== test/bus_align_bench.sv
// Self-checking bench for the external bus alignment block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    err_total++; $display("Error %s expected %h seen %h", n, e, s); end end
module bus_align_bench;
    logic        clk_i = 0, rst_i = 1, pin = 0, req = 0, lit_exp = 0;
    logic [1:0]  wid = 0, size = 0, stall = 0;
    logic [31:0] addr = 0, wdata = 0, eaddr, edata;
    logic        busy, done, valid, rdy, s3, s2, s1, s0, little;
    int          err_total = 0, cmp_count = 0;
    bus_align dut (.clk_i(clk_i), .rst_i(rst_i), .endian_select_pin_i(pin),
        .dev_width_i(wid), .req_i(req), .size_i(size), .addr_i(addr),
        .wdata_i(wdata), .busy_o(busy), .done_o(done), .ext_valid_o(valid),
        .ext_ready_i(rdy), .ext_addr_o(eaddr), .ext_data_o(edata),
        .lane3_write_strobe_o(s3), .lane2_write_strobe_o(s2),
        .lane1_write_strobe_o(s1), .lane0_write_strobe_o(s0),
        .little_endian_o(little));
    ext_device mem (.clk_i(clk_i), .rst_i(rst_i), .valid_i(valid),
        .stall_i(stall), .ready_o(rdy));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Strobes in bits 35:32, lane data below
    function automatic logic [35:0] beat(int wb, int sb, int o, int b,
                                         logic [31:0] w);
        int ub; int u; int pos; logic [31:0] d; logic [3:0] m;
        ub = (sb > wb) ? wb : sb;
        u = lit_exp ? b : sb / ub - 1 - b;
        d = w >> (u * ub * 8);
        if (ub < 4) d = d & ((32'h1 << (ub * 8)) - 32'h1);
        pos = (sb >= wb) ? 0 : (lit_exp ? o % wb : wb - sb - o % wb);
        m = 4'(((32'h1 << ub) - 32'h1) << pos);
        return {m, d << (pos * 8)};
    endfunction
    task automatic access(int wc, int sc, int o, logic [31:0] wd);
        int wb; int sb; int t; logic [35:0] e; logic [31:0] lm;
        // Code 3 is expected to behave like a byte-wide device
        wb = (wc == 1) ? 2 : (wc == 2) ? 4 : 1;
        sb = 1 << sc;
        // Outputs are read 1 ns after an edge, inputs change on it
        @(posedge clk_i);
        #1;
        while (busy !== 1'b0) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        wid <= 2'(wc); size <= 2'(sc); addr <= 32'h1000 + o;
        wdata <= wd; stall <= 2'(o); req <= 1'b1;
        @(posedge clk_i);
        req <= 1'b0;
        #1 `CHECK("busy", 1'b1, busy)
        for (int b = 0; b < ((sb > wb) ? sb / wb : 1); b++) begin
            t = 0;
            do begin
                @(posedge clk_i);
                #1;
                t++;
            end while (!(valid === 1'b1 && rdy === 1'b1) && t < 20);
            `CHECK("accept", 1'b1, valid & rdy)
            e = beat(wb, sb, o, b, wd);
            lm = {{8{e[35]}}, {8{e[34]}}, {8{e[33]}}, {8{e[32]}}};
            `CHECK("strobes", e[35:32], {s3, s2, s1, s0})
            `CHECK("data", e[31:0], edata & lm)
            `CHECK("addr", 32'h1000 + o + b * wb, eaddr)
            if (wb < 4) `CHECK("upper", 16'h0, edata[31:16])
        end
        // The final beat is taken at this edge and done follows it
        @(posedge clk_i);
        #1 `CHECK("done", 1'b1, done)
    endtask
    task automatic strap_reset(logic p);
        @(posedge clk_i);
        rst_i <= 1'b1;
        pin <= p;
        lit_exp = p;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 `CHECK("little", p, little)
    endtask
    task automatic run_all();
        for (int w = 0; w < 3; w++)
            for (int s = 0; s < 3; s++)
                for (int o = 0; o < 4; o += (1 << s))
                    access(w, s, o, 32'h8c4d2e1f ^ (o * 32'h01010101));
    endtask
    task automatic test_big();
        strap_reset(1'b0);
        run_all();
        $display("test big endian done");
    endtask
    task automatic test_strap_hold();
        // A late change on the pin must not flip the ordering mid-run
        @(posedge clk_i);
        pin <= 1'b1;
        access(0, 1, 2, 32'h0000a55a);
        access(3, 2, 0, 32'h3cc35aa5);
        `CHECK("little held", 1'b0, little)
        $display("test strap hold done");
    endtask
    task automatic test_little();
        strap_reset(1'b1);
        run_all();
        $display("test little endian done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        test_big();
        test_strap_hold();
        test_little();
        finish_test();
    end
endmodule
`default_nettype wire
